// ### logic/ptf_cfg.svh
// Constants of the paging translation and fault unit.
`ifndef PTF_CFG_SVH
`define PTF_CFG_SVH
`define PTF_TLB_ENTRIES 32
`define PTF_TLB_WAYS    4
`define PTF_TLB_SETS    8
`define PTF_OFF_DIRBASE 8'h00
`define PTF_OFF_FADDR   8'h04
`define PTF_OFF_FSTAT   8'h08
`define PTF_OFF_FIP     8'h0C
`define PTF_DIRBASE_RST 32'h0000_0000
`define PTF_BIT_P       0
`define PTF_BIT_RW      1
`define PTF_BIT_US      2
`define PTF_BIT_A       5
`define PTF_BIT_D       6
`define PTF_VEC_PF      8'h0E
`define PTF_VEC_DF      8'h08
`define PTF_RESP_OKAY   2'b00
`define PTF_RESP_SLVERR 2'b10
`endif

// ### logic/ptf_pkg.sv
// Types shared by the paging translation and fault unit.
package ptf_pkg;
  typedef enum logic [3:0] {
    PTF_IDLE   = 4'b0000,
    PTF_CHECK  = 4'b0001,
    PTF_PDE_RD = 4'b0010,
    PTF_PDE_WR = 4'b0011,
    PTF_PTE_RD = 4'b0100,
    PTF_PTE_WR = 4'b0101,
    PTF_FILL   = 4'b0110,
    PTF_DONE   = 4'b0111,
    PTF_FAULT  = 4'b1000
  } ptf_state_t;
  typedef logic [19:0] ptf_vpn_t;
endpackage

// ### logic/ptf_tlb.sv
// Four-way, 32-entry translation cache with a fully parallel tag compare.
`timescale 1ns/10ps
`include "ptf_cfg.svh"
module ptf_tlb
  import ptf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        flush,
  input  wire ptf_vpn_t    look_vpn,
  output logic             hit,
  output logic [19:0]      hit_frame,
  output logic             hit_user,
  output logic             hit_wr,
  output logic             hit_dirty,
  output logic             any_valid,
  input  wire logic        fill,
  input  wire logic [19:0] fill_frame,
  input  wire logic        fill_user,
  input  wire logic        fill_wr,
  input  wire logic        fill_dirty
);
  logic [`PTF_TLB_ENTRIES-1:0] valid_r;
  logic [`PTF_TLB_ENTRIES-1:0] match;
  ptf_vpn_t    tag_r   [`PTF_TLB_ENTRIES];
  logic [19:0] frame_r [`PTF_TLB_ENTRIES];
  logic [2:0]  attr_r  [`PTF_TLB_ENTRIES];
  logic [1:0]  rr_r    [`PTF_TLB_SETS];
  logic [4:0]  hit_idx;
  logic [4:0]  fill_idx;

  // Every entry is compared at once; the set index only steers replacement.
  genvar e;
  generate
    for (e = 0; e < `PTF_TLB_ENTRIES; e++) begin : g_cmp
      assign match[e] = valid_r[e] && (tag_r[e] == look_vpn);
    end
  endgenerate

  always_comb begin
    hit_idx = 5'd0;
    for (int i = 0; i < `PTF_TLB_ENTRIES; i++) begin
      if (match[i]) begin
        hit_idx = 5'(i);
      end
    end
  end

  assign hit       = |match;
  assign any_valid = |valid_r;
  assign hit_frame = frame_r[hit_idx];
  assign hit_user  = attr_r[hit_idx][2];
  assign hit_wr    = attr_r[hit_idx][1];
  assign hit_dirty = attr_r[hit_idx][0];
  // A stale hit on the same page is overwritten in place, else round robin.
  assign fill_idx  = hit ? hit_idx : {look_vpn[2:0], rr_r[look_vpn[2:0]]};

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      valid_r <= '0;
    end else if (fill) begin
      valid_r[fill_idx] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (fill) begin
      tag_r[fill_idx]   <= look_vpn;
      frame_r[fill_idx] <= fill_frame;
      attr_r[fill_idx]  <= {fill_user, fill_wr, fill_dirty};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < `PTF_TLB_SETS; s++) begin
        rr_r[s] <= 2'd0;
      end
    end else if (fill && !hit) begin
      rr_r[look_vpn[2:0]] <= rr_r[look_vpn[2:0]] + 2'd1;
    end
  end
endmodule

// ### logic/ptf_fault_code.sv
// Page rights check and 16-bit page fault cause code.
`timescale 1ns/10ps
module ptf_fault_code (
  input  wire logic  dir_user,
  input  wire logic  dir_wr,
  input  wire logic  tab_user,
  input  wire logic  tab_wr,
  input  wire logic  acc_user,
  input  wire logic  acc_write,
  input  wire logic  acc_desc,
  input  wire logic  not_present,
  output logic       viol,
  output logic [15:0] err_code
);
  logic eff_user;
  logic pg_user;
  logic pg_wr;
  // Descriptor table accesses count as supervisor accesses.
  assign eff_user = acc_user && !acc_desc;
  assign pg_user  = dir_user && tab_user;
  assign pg_wr    = dir_wr && tab_wr;
  assign viol     = eff_user && (!pg_user || (acc_write && !pg_wr));
  assign err_code = {13'h0000, eff_user, acc_write, !not_present};
endmodule

// ### logic/ptf_paging.sv
// Paging translation unit: cache lookup, table walk, faults and registers.
//
// Function
// - Compare top 20 linear bits against all 32 cache tags at once.
// - On a hit without a rights violation, except a write to a clean entry, drive the physical address with no table reads.
// - On a miss first read the selected directory entry.
// - Present directory entry: read table entry and set its accessed flag.
// - Present table entry: set accessed, dirty on writes, before answering.
// - After a walk load the 20-bit frame into the cache, unless a flush came during the walk.
// - Present flag 0 in either entry aborts with fault vector 14.
// - Rights violations also raise vector 14.
// - Every fault captures the linear address in the fault address register.
// - Fault during handler entry re-raises vector 14, never vector 8.
// - Faults save the faulting instruction pointer for restart.
// - Faults carry a 16-bit cause code.
// - Code bit 2 is 1 for user, 0 for supervisor.
// - Code bit 1 is 0 for read, 1 for write.
// - Code bit 0 is 0 for not present, 1 for protection.
// - Descriptor table faults report supervisor in bit 2.
// - Writing the directory base register empties the cache.
// - Task switch reloads directory base from the incoming task record.
// - Bits 31:22 index directory, 21:12 table; frame joins bits 11:0.
// - Accessed and dirty updates use locked read-modify-write cycles.
// - Page rights are the stricter of both entries; supervisor bypasses.
// - Cache is four-way set associative, 32 entries.
`timescale 1ns/10ps
`include "ptf_cfg.svh"
module ptf_paging
  import ptf_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axil_awvalid,
  output logic             s_axil_awready,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic [2:0]  s_axil_awprot,
  input  wire logic        s_axil_wvalid,
  output logic             s_axil_wready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  output logic             s_axil_bvalid,
  input  wire logic        s_axil_bready,
  output logic [1:0]       s_axil_bresp,
  input  wire logic        s_axil_arvalid,
  output logic             s_axil_arready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic [2:0]  s_axil_arprot,
  output logic             s_axil_rvalid,
  input  wire logic        s_axil_rready,
  output logic [31:0]      s_axil_rdata,
  output logic [1:0]       s_axil_rresp,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [31:0] req_lin_addr,
  input  wire logic        req_write,
  input  wire logic        req_user,
  input  wire logic        req_desc,
  input  wire logic [31:0] req_instruction_pointer,
  input  wire logic        handler_entry,
  output logic             rsp_valid,
  output logic             rsp_fault,
  output logic [31:0]      rsp_phys_addr,
  output logic [7:0]       rsp_vector,
  output logic [15:0]      rsp_err_code,
  output logic             rsp_refault,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic [31:0]      mem_addr,
  output logic             mem_write,
  output logic [31:0]      mem_wdata,
  output logic             mem_lock,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        task_switch,
  input  wire logic [31:0] task_state_record_dir_base
);
  ptf_state_t  state_r;
  logic [31:0] lin_r;
  logic        wr_r;
  logic        user_r;
  logic        desc_r;
  logic        hnd_r;
  logic [31:0] ip_r;
  logic [31:0] pde_r;
  logic [31:0] pte_r;
  logic [31:0] directory_base_reg_r;
  logic [31:0] fault_linear_address_reg_r;
  logic [31:0] fault_ip_r;
  logic        flush_pend_r;
  logic        tlb_hit;
  logic [19:0] tlb_frame;
  logic        tlb_user;
  logic        tlb_wr;
  logic        tlb_dirty;
  logic        tlb_any;
  logic        tlb_fill;
  logic        flush;
  logic        fc_viol;
  logic [15:0] fc_err;
  logic        fc_np;
  logic        fc_dir_u;
  logic        fc_dir_w;
  logic        fc_tab_u;
  logic        fc_tab_w;
  logic        fault_go;
  logic        hit_ok;
  logic        aw_held_r;
  logic        w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic        dirbase_wr;
  logic        wr_fire;

  assign req_ready  = (state_r == PTF_IDLE);
  assign rsp_valid  = (state_r == PTF_DONE) || (state_r == PTF_FAULT);
  assign rsp_vector = `PTF_VEC_PF;
  assign flush      = dirbase_wr || task_switch;
  assign hit_ok     = tlb_hit && !fc_viol && !(wr_r && !tlb_dirty);
  // Fills are dropped if the mapping was flushed while the walk was running.
  assign tlb_fill   = (state_r == PTF_FILL) && !flush_pend_r && !flush;

  ptf_tlb u_tlb (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .flush      (flush),
    .look_vpn   (lin_r[31:12]),
    .hit        (tlb_hit),
    .hit_frame  (tlb_frame),
    .hit_user   (tlb_user),
    .hit_wr     (tlb_wr),
    .hit_dirty  (tlb_dirty),
    .any_valid  (tlb_any),
    .fill       (tlb_fill),
    .fill_frame (pte_r[31:12]),
    .fill_user  (pde_r[`PTF_BIT_US] && pte_r[`PTF_BIT_US]),
    .fill_wr    (pde_r[`PTF_BIT_RW] && pte_r[`PTF_BIT_RW]),
    .fill_dirty (pte_r[`PTF_BIT_D])
  );

  // Cached rights are checked on a hit, fetched rights during the walk.
  always_comb begin
    fc_dir_u = pde_r[`PTF_BIT_US];
    fc_dir_w = pde_r[`PTF_BIT_RW];
    fc_tab_u = mem_rdata[`PTF_BIT_US];
    fc_tab_w = mem_rdata[`PTF_BIT_RW];
    if (state_r == PTF_CHECK) begin
      fc_dir_u = tlb_user;
      fc_dir_w = tlb_wr;
      fc_tab_u = tlb_user;
      fc_tab_w = tlb_wr;
    end
  end
  assign fc_np = ((state_r == PTF_PDE_RD) || (state_r == PTF_PTE_RD)) &&
                 !mem_rdata[`PTF_BIT_P];

  ptf_fault_code u_fc (
    .dir_user    (fc_dir_u),
    .dir_wr      (fc_dir_w),
    .tab_user    (fc_tab_u),
    .tab_wr      (fc_tab_w),
    .acc_user    (user_r),
    .acc_write   (wr_r),
    .acc_desc    (desc_r),
    .not_present (fc_np),
    .viol        (fc_viol),
    .err_code    (fc_err)
  );

  assign fault_go = ((state_r == PTF_CHECK) && tlb_hit && fc_viol) ||
                    ((state_r == PTF_PDE_RD) && mem_ready && fc_np) ||
                    ((state_r == PTF_PTE_RD) && mem_ready && (fc_np || fc_viol));

  // Walk sequencer; each table update keeps the bus locked from read to write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= PTF_IDLE;
      mem_valid <= 1'b0;
      mem_write <= 1'b0;
      mem_lock  <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      pde_r     <= 32'h0000_0000;
      pte_r     <= 32'h0000_0000;
    end else begin
      case (state_r)
        PTF_IDLE: begin
          if (req_valid) begin
            state_r <= PTF_CHECK;
          end
        end
        PTF_CHECK: begin
          if (fault_go) begin
            state_r <= PTF_FAULT;
          end else if (hit_ok) begin
            state_r <= PTF_DONE;
          end else begin
            state_r   <= PTF_PDE_RD;
            mem_valid <= 1'b1;
            mem_write <= 1'b0;
            mem_lock  <= 1'b1;
            mem_addr  <= {directory_base_reg_r[31:12], lin_r[31:22], 2'b00};
          end
        end
        PTF_PDE_RD: begin
          if (mem_ready) begin
            pde_r <= mem_rdata;
            if (fault_go) begin
              state_r   <= PTF_FAULT;
              mem_valid <= 1'b0;
              mem_lock  <= 1'b0;
            end else if (!mem_rdata[`PTF_BIT_A]) begin
              state_r   <= PTF_PDE_WR;
              mem_write <= 1'b1;
              mem_wdata <= mem_rdata | (32'h0000_0001 << `PTF_BIT_A);
            end else begin
              state_r  <= PTF_PTE_RD;
              mem_addr <= {mem_rdata[31:12], lin_r[21:12], 2'b00};
            end
          end
        end
        PTF_PDE_WR: begin
          if (mem_ready) begin
            state_r   <= PTF_PTE_RD;
            mem_write <= 1'b0;
            mem_addr  <= {pde_r[31:12], lin_r[21:12], 2'b00};
          end
        end
        PTF_PTE_RD: begin
          if (mem_ready) begin
            pte_r <= mem_rdata;
            if (fault_go) begin
              state_r   <= PTF_FAULT;
              mem_valid <= 1'b0;
              mem_lock  <= 1'b0;
            end else if (!mem_rdata[`PTF_BIT_A] || (wr_r && !mem_rdata[`PTF_BIT_D])) begin
              state_r   <= PTF_PTE_WR;
              mem_write <= 1'b1;
              mem_wdata <= mem_rdata | (32'h0000_0001 << `PTF_BIT_A) |
                           ({31'h0000_0000, wr_r} << `PTF_BIT_D);
              pte_r     <= mem_rdata | (32'h0000_0001 << `PTF_BIT_A) |
                           ({31'h0000_0000, wr_r} << `PTF_BIT_D);
            end else begin
              state_r   <= PTF_FILL;
              mem_valid <= 1'b0;
              mem_lock  <= 1'b0;
            end
          end
        end
        PTF_PTE_WR: begin
          if (mem_ready) begin
            state_r   <= PTF_FILL;
            mem_valid <= 1'b0;
            mem_write <= 1'b0;
            mem_lock  <= 1'b0;
          end
        end
        PTF_FILL: begin
          state_r <= PTF_DONE;
        end
        PTF_DONE: begin
          state_r <= PTF_IDLE;
        end
        PTF_FAULT: begin
          state_r <= PTF_IDLE;
        end
        default: begin
          state_r <= PTF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lin_r  <= 32'h0000_0000;
      wr_r   <= 1'b0;
      user_r <= 1'b0;
      desc_r <= 1'b0;
      hnd_r  <= 1'b0;
      ip_r   <= 32'h0000_0000;
    end else if (req_valid && req_ready) begin
      lin_r  <= req_lin_addr;
      wr_r   <= req_write;
      user_r <= req_user;
      desc_r <= req_desc;
      hnd_r  <= handler_entry;
      ip_r   <= req_instruction_pointer;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_phys_addr <= 32'h0000_0000;
    end else if ((state_r == PTF_CHECK) && hit_ok) begin
      rsp_phys_addr <= {tlb_frame, lin_r[11:0]};
    end else if (state_r == PTF_FILL) begin
      rsp_phys_addr <= {pte_r[31:12], lin_r[11:0]};
    end
  end

  // Fault capture; a fault during handler entry is flagged but keeps vector 14.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_fault                  <= 1'b0;
      rsp_err_code               <= 16'h0000;
      rsp_refault                <= 1'b0;
      fault_linear_address_reg_r <= 32'h0000_0000;
      fault_ip_r                 <= 32'h0000_0000;
    end else begin
      rsp_fault <= fault_go;
      if (fault_go) begin
        rsp_err_code               <= fc_err;
        rsp_refault                <= hnd_r;
        fault_linear_address_reg_r <= lin_r;
        fault_ip_r                 <= ip_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      directory_base_reg_r <= `PTF_DIRBASE_RST;
    end else if (task_switch) begin
      directory_base_reg_r <= {task_state_record_dir_base[31:12], 12'h000};
    end else if (dirbase_wr) begin
      directory_base_reg_r <= {wdata_r[31:12], 12'h000};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || (state_r == PTF_IDLE)) begin
      flush_pend_r <= 1'b0;
    end else if (flush) begin
      flush_pend_r <= 1'b1;
    end
  end

  // AXI4-Lite write side; address and data are taken in either order.
  assign s_axil_awready = !aw_held_r && !s_axil_bvalid;
  assign s_axil_wready  = !w_held_r && !s_axil_bvalid;
  assign wr_fire        = aw_held_r && w_held_r && !s_axil_bvalid;
  assign dirbase_wr     = wr_fire && (awaddr_r == `PTF_OFF_DIRBASE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= `PTF_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= {s_axil_awaddr[7:2], 2'b00};
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axil_wdata;
      end
      if (wr_fire) begin
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= (awaddr_r == `PTF_OFF_DIRBASE) ? `PTF_RESP_OKAY : `PTF_RESP_SLVERR;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  assign s_axil_arready = !s_axil_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h0000_0000;
      s_axil_rresp  <= `PTF_RESP_OKAY;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp  <= `PTF_RESP_OKAY;
      case ({s_axil_araddr[7:2], 2'b00})
        `PTF_OFF_DIRBASE: s_axil_rdata <= directory_base_reg_r;
        `PTF_OFF_FADDR:   s_axil_rdata <= fault_linear_address_reg_r;
        `PTF_OFF_FSTAT:   s_axil_rdata <= {15'h0000, rsp_refault, rsp_err_code};
        `PTF_OFF_FIP:     s_axil_rdata <= fault_ip_r;
        default: begin
          s_axil_rdata <= 32'h0000_0000;
          s_axil_rresp <= `PTF_RESP_SLVERR;
        end
      endcase
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  sequence s_fill;
    state_r == PTF_FILL;
  endsequence
  sequence s_done_frame;
    rsp_valid && !rsp_fault && (rsp_phys_addr[31:12] == $past(pte_r[31:12]));
  endsequence

  a_fault_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    rsp_valid && rsp_fault |-> rsp_vector == 8'h0E) else $error("fault vector not 14");
  a_hit_no_walk: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PTF_CHECK && hit_ok |=> rsp_valid && !mem_valid &&
    rsp_phys_addr == {$past(tlb_frame), lin_r[11:0]}) else $error("hit walked");
  a_miss_pde: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PTF_CHECK && !tlb_hit |=> mem_valid && !mem_write && mem_lock &&
    mem_addr == {$past(directory_base_reg_r[31:12]), lin_r[31:22], 2'b00})
    else $error("no pde read");
  a_np_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == PTF_PDE_RD && mem_ready && !mem_rdata[0] |=> rsp_fault ##0 !rsp_err_code[0])
    else $error("not present missed");
  a_fault_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    rsp_valid && rsp_fault |-> fault_linear_address_reg_r == lin_r && rsp_err_code[1] == wr_r)
    else $error("fault capture wrong");
  a_err_code: assert property (@(posedge aclk) disable iff (!aresetn)
    rsp_fault |-> rsp_err_code[15:3] == 13'h0000 && (!desc_r || !rsp_err_code[2]))
    else $error("cause code wrong");
  a_lock_update: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == PTF_PDE_WR || state_r == PTF_PTE_WR) |-> mem_lock && mem_write &&
    mem_wdata[5]) else $error("unlocked update");
  a_fill_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    s_fill |=> s_done_frame) else $error("fill frame wrong");
  a_flush_all: assert property (@(posedge aclk) disable iff (!aresetn)
    dirbase_wr |=> !tlb_any) else $error("cache not flushed");
  a_task_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    task_switch |=> directory_base_reg_r[31:12] == $past(task_state_record_dir_base[31:12]))
    else $error("task base not loaded");
endmodule

// ### dv/ptf_mem_mdl.sv
// Behavioural table memory that answers the walker after a chosen number of wait cycles.
`timescale 1ns/10ps
module ptf_mem_mdl (
  input  wire logic        aclk,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  lat,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [0:4095];
  logic [1:0]  wait_r;
  logic [31:0] last_r;
  // Outside a transfer the data lines show the inverse of the last word, never a stale copy.
  assign mem_ready = mem_valid && (wait_r == lat);
  assign mem_rdata = mem_ready ? mem[mem_addr[13:2]] : ~last_r;
  always @(posedge aclk) begin
    if (!mem_valid || mem_ready) begin
      wait_r <= 2'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
    if (mem_ready) begin
      last_r <= mem_rdata;
      if (mem_write) begin
        mem[mem_addr[13:2]] <= mem_wdata;
      end
    end
  end
  initial begin
    wait_r = 2'h0;
    last_r = 32'h0000_0000;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 32'h0000_0000;
    end
  end
endmodule

// ### dv/tb_ptf_paging.sv
// Self-checking bench of the paging unit against the table memory model.
`timescale 1ns/10ps
module tb_ptf_paging;
  logic aclk, aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid;
  logic s_axil_rready, req_valid, req_write, req_user, req_desc, handler_entry, task_switch;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, f, rf;
  logic req_ready, rsp_valid, rsp_fault, rsp_refault, mem_valid, mem_ready, mem_write, mem_lock;
  logic [7:0]  s_axil_awaddr, s_axil_araddr, rsp_vector;
  logic [2:0]  s_axil_awprot, s_axil_arprot;
  logic [3:0]  s_axil_wstrb;
  logic [1:0]  s_axil_bresp, s_axil_rresp, lat, rs;
  logic [15:0] rsp_err_code, lf, ec;
  logic [31:0] s_axil_wdata, s_axil_rdata, req_lin_addr, req_instruction_pointer, rsp_phys_addr;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, task_state_record_dir_base, rd, la, lb, pa;
  logic [19:0] fr;
  logic [9:0]  dx, tx;
  int          err_total = 0, n_compared = 0, n_mem = 0, cyc = 0, n;

  ptf_paging dut (.*);
  ptf_mem_mdl mdl (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Cause code for mode bits {desc, write, user}.
  function automatic logic [15:0] exp_err(input logic [2:0] m, input logic prot);
    return {13'h0000, m[0] & ~m[2], m[1], prot};
  endfunction

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (mem_valid === 1'b1) begin
      n_mem <= n_mem + 1;
    end
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axil_awvalid <= 1'b1;
    s_axil_awaddr <= a;
    s_axil_wvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    rs = s_axil_bresp;
  endtask

  task automatic axr(input logic [7:0] a);
    s_axil_arvalid <= 1'b1;
    s_axil_araddr <= a;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    rd = s_axil_rdata;
    rs = s_axil_rresp;
  endtask

  task automatic xlate(input logic [31:0] a, input logic [2:0] m, input logic he);
    req_valid <= 1'b1;
    req_lin_addr <= a;
    {req_desc, req_write, req_user} <= m;
    handler_entry <= he;
    do @(posedge aclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge aclk); while (rsp_valid !== 1'b1);
    {f, rf, ec, pa} = {rsp_fault, rsp_refault, rsp_err_code, rsp_phys_addr};
  endtask

  initial begin
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid} = '0;
    {s_axil_rready, req_valid, req_write, req_user, req_desc, handler_entry, task_switch} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_awprot, s_axil_arprot, s_axil_wdata, lat} = '0;
    {req_lin_addr, req_instruction_pointer, task_state_record_dir_base} = '0;
    s_axil_wstrb = 4'hF;
    lf = 16'h000C;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    lf = lfsr(lf);
    dx = lf[9:0];
    lf = lfsr(lf);
    tx = lf[9:0];
    fr = {lf[3:0], lf};
    la = {dx, tx, lf[11:0]};
    lat <= 2'h2;
    axw(8'h00, 32'h0000_1000);
    chk(rs, 2'b00);
    mdl.mem[1024 + dx] = 32'h0000_2007;
    mdl.mem[2048 + tx] = {fr, 12'h007};
    xlate(la, 3'b011, 1'b0);
    chk(pa, {fr, la[11:0]});
    chk(mdl.mem[2048 + tx], {fr, 12'h067});
    chk(mdl.mem[1024 + dx][5], 1'b1);
    n = n_mem;
    xlate(la ^ 32'h0000_0ABC, 3'b001, 1'b0);
    chk(n_mem - n, 0);
    chk(pa, {fr, la[11:0] ^ 12'hABC});
    $display("test walk and hit done");
    lat <= 2'h0;
    lb = {dx, tx ^ 10'h001, lf[11:0]};
    mdl.mem[2048 + (tx ^ 10'h001)] = {fr ^ 20'h0_0001, 12'h005};
    req_instruction_pointer <= {lf, lf};
    xlate(lb, 3'b011, 1'b0);
    chk({f, rsp_vector, ec}, {1'b1, 8'h0E, exp_err(3'b011, 1'b1)});
    axr(8'h04);
    chk(rd, lb);
    axr(8'h0C);
    chk(rd, {lf, lf});
    axr(8'h08);
    chk(rd, {15'h0000, 1'b0, exp_err(3'b011, 1'b1)});
    xlate(lb, 3'b010, 1'b0);
    chk(f, 1'b0);
    chk(pa, {fr ^ 20'h0_0001, lb[11:0]});
    $display("test protection done");
    mdl.mem[1024 + (dx ^ 10'h001)] = 32'h0000_2006;
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      xlate({dx ^ 10'h001, lf[9:0], lf[15:4]}, i[2:0], i[0]);
      chk({f, rf, ec}, {1'b1, i[0], exp_err(i[2:0], 1'b0)});
    end
    $display("test not present done");
    mdl.mem[2048 + tx] = {fr ^ 20'h0_0010, 12'h067};
    axw(8'h00, 32'h0000_1000);
    xlate(la, 3'b000, 1'b0);
    chk(pa, {fr ^ 20'h0_0010, la[11:0]});
    $display("test flush done");
    mdl.mem[3072 + dx] = 32'h0000_2007;
    task_switch <= 1'b1;
    task_state_record_dir_base <= 32'h0000_3000;
    @(posedge aclk);
    task_switch <= 1'b0;
    axr(8'h00);
    chk(rd, 32'h0000_3000);
    n = n_mem;
    xlate(la, 3'b000, 1'b0);
    chk(n_mem != n, 1'b1);
    axr(8'h10);
    chk(rs, 2'b10);
    axw(8'h04, 32'h0000_0000);
    chk(rs, 2'b10);
    $display("test task switch done");
    report_and_stop();
  end
endmodule
